// ### pcmq_regs.svh
// Purpose : Offsets, field positions, reset values and codes for the law translator
//           and quadrant bit replacement block.
// Assumes : 16-bit microprocessor port with word addresses A13-0.
// Notes   : Definitions only.
// How it works
// RULE1 - Law translation runs on every output channel, connection or message traffic.
// RULE2 - Connection-memory-high bit 4 picks voice (0) or data (1) coding.
// RULE3 - Input law sits at bits 3-2, output law at bits 1-0.
// RULE4 - Voice codes: 00 A-law, 01 mu-law, 10 A-law even bits plain, 11 mu-law magnitude plain.
// RULE5 - A-law without alternate-bit inversion keeps even bits 6,4,2,0 uninverted.
// RULE6 - Mu-law without magnitude inversion keeps magnitude bits 6-0 uninverted.
// RULE7 - Data code 00 is plain, nothing inverted.
// RULE8 - Data code 01 inverts even bits 6,4,2,0.
// RULE9 - Data code 10 inverts odd bits 7,5,3,1.
// RULE10 - Data code 11 inverts all eight bits.
// RULE11 - Differing input and output laws convert the byte between them.
// RULE12 - Equal input and output laws pass the byte untouched.
// RULE13 - One voice/data bit per channel, so no voice-to-data conversion.
// RULE14 - Frame splits into four quadrants of 8, 16, 32 or 64 channels by rate.
// RULE15 - Quadrant controls: Q3 bits 11-9, Q2 8-6, Q1 5-3, Q0 2-0.
// RULE16 - 0xx normal, 100/101 force LSB 0/1, 110/111 force MSB 0/1.
// RULE17 - Software never enables quadrant replacement and BER reception on one stream.
// RULE18 - Thirty-two quadrant registers live at 0x0120 to 0x013F, read/write.
// RULE19 - Replacement hits every frame's input byte before the data memory write.
`ifndef PCMQ_REGS_SVH
`define PCMQ_REGS_SVH

`define PCMQ_ADDR_W          14
`define PCMQ_QCTRL_BASE      14'h0120
`define PCMQ_QCTRL_LAST      14'h013F
`define PCMQ_QCTRL_RESET     12'h000
`define PCMQ_QCTRL_BITS      12
`define PCMQ_QFIELD_W        3
`define PCMQ_Q0_LSB          0
`define PCMQ_Q1_LSB          3
`define PCMQ_Q2_LSB          6
`define PCMQ_Q3_LSB          9

`define PCMQ_CMH_VD_BIT      4
`define PCMQ_CMH_INLAW_LSB   2
`define PCMQ_CMH_OUTLAW_LSB  0

`define PCMQ_MASK_PLAIN      8'h00
`define PCMQ_MASK_EVEN       8'h55
`define PCMQ_MASK_ODD        8'hAA
`define PCMQ_MASK_ALL        8'hFF
`define PCMQ_MASK_MAG        8'h7F

`define PCMQ_MU_BIAS         13'h0021
`define PCMQ_A_SEG_STEP      13'h0040
`define PCMQ_A_SEG0_TOP      12'h020

`endif

// ### pcmq_pkg.sv
// Purpose : Types shared by the law translator and quadrant replacement block.
// Assumes : Constants come from pcmq_regs.svh.
// Notes   : Enum codes match the connection memory and rate encodings.
package pcmq_pkg;

    typedef enum logic [1:0]
    {
        PCMQ_RATE_2M  = 2'b00,
        PCMQ_RATE_4M  = 2'b01,
        PCMQ_RATE_8M  = 2'b10,
        PCMQ_RATE_16M = 2'b11
    } pcmq_rate_e;

    typedef enum logic [1:0]
    {
        PCMQ_LAW_A       = 2'b00,
        PCMQ_LAW_MU      = 2'b01,
        PCMQ_LAW_A_NOABI = 2'b10,
        PCMQ_LAW_MU_NOMI = 2'b11
    } pcmq_law_e;

    typedef enum logic [0:0]
    {
        PCMQ_CPU_IDLE = 1'b0,
        PCMQ_CPU_HOLD = 1'b1
    } pcmq_cpu_state_e;

    typedef logic [2:0] pcmq_qctrl_t;

endpackage : pcmq_pkg

// ### pcmq_law_xlate.sv
// Purpose : Per-channel code-law translation of one output channel byte.
// Assumes : Connection-memory-high entry arrives with the byte, same clock.
// Notes   : One register stage; result follows i_valid by one edge.
`timescale 1ns/1ps
`default_nettype none
`include "pcmq_regs.svh"

module pcmq_law_xlate
    import pcmq_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_sys_rst,
    // Channel in
    input  wire logic       i_valid,
    input  wire logic [4:0] i_cmh,
    input  wire logic [7:0] i_byte,
    // Channel out
    output logic            o_valid,
    output logic [7:0]      o_byte
);

    // RULE7 RULE8 RULE9 RULE10 data masks
    function automatic logic [7:0] data_mask(input logic [1:0] code);
        case (code)
            2'b00:   data_mask = `PCMQ_MASK_PLAIN;
            2'b01:   data_mask = `PCMQ_MASK_EVEN;
            2'b10:   data_mask = `PCMQ_MASK_ODD;
            default: data_mask = `PCMQ_MASK_ALL;
        endcase
    endfunction : data_mask

    // RULE4 RULE5 RULE6 line form to plain code
    function automatic logic [7:0] voice_mask(input logic [1:0] code);
        case (pcmq_law_e'(code))
            PCMQ_LAW_A:  voice_mask = `PCMQ_MASK_EVEN;
            PCMQ_LAW_MU: voice_mask = `PCMQ_MASK_MAG;
            default:     voice_mask = `PCMQ_MASK_PLAIN;
        endcase
    endfunction : voice_mask

    function automatic logic [3:0] msb_pos(input logic [12:0] v);
        msb_pos = 4'h0;
        for (int i = 0; i < 13; i++)
            if (v[i])
                msb_pos = 4'(i);
    endfunction : msb_pos

    // Magnitudes in a common 13-bit linear scale
    function automatic logic [12:0] a_to_lin(input logic [6:0] c);
        logic [12:0] step;
        step = {7'h00, c[3:0], 2'b10};
        if (c[6:4] == 3'h0)
            a_to_lin = step;
        else
            a_to_lin = 13'((step + `PCMQ_A_SEG_STEP) << (c[6:4] - 3'h1));
    endfunction : a_to_lin

    function automatic logic [12:0] mu_to_lin(input logic [6:0] c);
        logic [12:0] step;
        step = 13'({8'h00, c[3:0], 1'b0} + `PCMQ_MU_BIAS);
        mu_to_lin = 13'((step << c[6:4]) - `PCMQ_MU_BIAS);
    endfunction : mu_to_lin

    function automatic logic [6:0] lin_to_mu(input logic [12:0] lin);
        logic [12:0] v;
        logic [2:0]  seg;
        logic [12:0] sh;
        v   = 13'(lin + `PCMQ_MU_BIAS);
        seg = 3'(msb_pos(v) - 4'h5);
        sh  = v >> ({1'b0, seg} + 4'h1);
        lin_to_mu = {seg, sh[3:0]};
    endfunction : lin_to_mu

    function automatic logic [6:0] lin_to_a(input logic [12:0] lin);
        logic [11:0] a;
        logic [2:0]  seg;
        logic [11:0] sh;
        a   = lin[12:1];
        seg = 3'(msb_pos({1'b0, a}) - 4'h4);
        sh  = a >> seg;
        if (a < `PCMQ_A_SEG0_TOP)
            lin_to_a = {3'h0, a[4:1]};
        else
            lin_to_a = {seg, sh[3:0]};
    endfunction : lin_to_a

    logic       is_data;
    logic [1:0] in_law;
    logic [1:0] out_law;
    logic [7:0] canon;
    logic [6:0] mag;
    logic [7:0] xlat;

    always_comb
    begin
        // RULE2 RULE3 field split
        is_data = i_cmh[`PCMQ_CMH_VD_BIT];
        in_law  = i_cmh[`PCMQ_CMH_INLAW_LSB +: 2];
        out_law = i_cmh[`PCMQ_CMH_OUTLAW_LSB +: 2];
        canon   = i_byte ^ voice_mask(in_law);
        mag     = canon[6:0];
        // RULE11 cross-family companding
        if (in_law[0] && !out_law[0])
            mag = lin_to_a(mu_to_lin(canon[6:0]));
        else if (!in_law[0] && out_law[0])
            mag = lin_to_mu(a_to_lin(canon[6:0]));
        // RULE12 same law passes
        if (in_law == out_law)
            xlat = i_byte;
        // RULE13 data stays data
        else if (is_data)
            xlat = i_byte ^ data_mask(in_law) ^ data_mask(out_law);
        else
            xlat = {canon[7], mag} ^ voice_mask(out_law);
    end

    // RULE1 applied to every channel
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_valid <= 1'b0;
            o_byte  <= 8'h00;
        end
        else
        begin
            o_valid <= i_valid;
            if (i_valid)
                o_byte <= xlat;
        end
    end

endmodule : pcmq_law_xlate
`default_nettype wire

// ### pcmq_top.sv
// Purpose : Quadrant bit replacement on input channels, law translation on output
//           channels, and the quadrant control registers on the microprocessor port.
// Assumes : Channel strobes come from switch logic on i_clk_sys; the port pins do not.
// Notes   : Port pins pass three flip-flops; strobes act once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
`include "pcmq_regs.svh"

module pcmq_top
    import pcmq_pkg::*;
#(
    parameter int NUM_STREAMS = 32
)
(
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    // Microprocessor port
    input  wire logic        i_cpu_cs_n,
    input  wire logic        i_cpu_rd_n,
    input  wire logic        i_cpu_wr_n,
    input  wire logic [13:0] i_cpu_addr,
    input  wire logic [15:0] i_cpu_d,
    output logic      [15:0] o_cpu_d,
    output logic             o_cpu_d_oe,
    output logic             o_cpu_dta_rdy_n,
    // Input channel toward data memory
    input  wire logic        i_in_valid,
    input  wire logic [4:0]  i_in_stream,
    input  wire logic [7:0]  i_in_chan,
    input  wire logic [1:0]  i_in_rate,
    input  wire logic [7:0]  i_in_byte,
    output logic             o_dm_valid,
    output logic      [4:0]  o_dm_stream,
    output logic      [7:0]  o_dm_chan,
    output logic      [7:0]  o_dm_byte,
    // Output channel from data memory
    input  wire logic        i_out_valid,
    input  wire logic [4:0]  i_out_cmh,
    input  wire logic [7:0]  i_out_byte,
    output logic             o_sto_valid,
    output logic      [7:0]  o_sto_byte
);

    // Stream count must fit the 5-bit stream number
    if (NUM_STREAMS < 1 || NUM_STREAMS > 32)
    begin : g_bad_streams
        $error("NUM_STREAMS must lie in 1..32");
    end

    // Four 3-bit fields must fill the register
    if (`PCMQ_Q3_LSB + `PCMQ_QFIELD_W != `PCMQ_QCTRL_BITS)
    begin : g_bad_fields
        $error("quadrant fields do not fill the control register");
    end

    // RULE14 quadrant from channel and rate
    function automatic logic [1:0] quad_of(input logic [1:0] rate, input logic [7:0] ch);
        case (pcmq_rate_e'(rate))
            PCMQ_RATE_2M:  quad_of = ch[4:3];
            PCMQ_RATE_4M:  quad_of = ch[5:4];
            PCMQ_RATE_8M:  quad_of = ch[6:5];
            default:       quad_of = ch[7:6];
        endcase
    endfunction : quad_of

    // RULE15 field select
    function automatic pcmq_qctrl_t qfield(input logic [11:0] r, input logic [1:0] q);
        case (q)
            2'd0:    qfield = r[`PCMQ_Q0_LSB +: `PCMQ_QFIELD_W];
            2'd1:    qfield = r[`PCMQ_Q1_LSB +: `PCMQ_QFIELD_W];
            2'd2:    qfield = r[`PCMQ_Q2_LSB +: `PCMQ_QFIELD_W];
            default: qfield = r[`PCMQ_Q3_LSB +: `PCMQ_QFIELD_W];
        endcase
    endfunction : qfield

    // RULE16 LSB or MSB forcing
    function automatic logic [7:0] bit_replace(input pcmq_qctrl_t qc, input logic [7:0] b);
        bit_replace = b;
        if (qc[2])
        begin
            if (qc[1])
                bit_replace[7] = qc[0];
            else
                bit_replace[0] = qc[0];
        end
    endfunction : bit_replace

    // RULE18 quadrant register window
    function automatic logic in_qwin(input logic [13:0] a);
        in_qwin = (a >= `PCMQ_QCTRL_BASE) && (a <= `PCMQ_QCTRL_LAST);
    endfunction : in_qwin

    // Port pin synchronisers: {cs_n, rd_n, wr_n}
    logic [2:0]  ctl_s1_reg;
    logic [2:0]  ctl_s2_reg;
    logic [2:0]  ctl_s3_reg;
    logic [2:0]  ctl_filt_reg;
    logic [13:0] addr_s1_reg;
    logic [13:0] addr_s2_reg;
    logic [13:0] addr_s3_reg;
    logic [15:0] data_s1_reg;
    logic [15:0] data_s2_reg;
    logic [15:0] data_s3_reg;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ctl_s1_reg   <= 3'h7;
            ctl_s2_reg   <= 3'h7;
            ctl_s3_reg   <= 3'h7;
            ctl_filt_reg <= 3'h7;
        end
        else
        begin
            ctl_s1_reg <= {i_cpu_cs_n, i_cpu_rd_n, i_cpu_wr_n};
            ctl_s2_reg <= ctl_s1_reg;
            ctl_s3_reg <= ctl_s2_reg;
            // Strobe bit moves once stages two and three agree
            for (int i = 0; i < 3; i++)
                if (ctl_s2_reg[i] == ctl_s3_reg[i])
                    ctl_filt_reg[i] <= ctl_s3_reg[i];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            addr_s1_reg <= 14'h0000;
            addr_s2_reg <= 14'h0000;
            addr_s3_reg <= 14'h0000;
        end
        else
        begin
            addr_s1_reg <= i_cpu_addr;
            addr_s2_reg <= addr_s1_reg;
            addr_s3_reg <= addr_s2_reg;
        end
    end

    // Write data settles before the filtered strobe acts
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            data_s1_reg <= 16'h0000;
            data_s2_reg <= 16'h0000;
            data_s3_reg <= 16'h0000;
        end
        else
        begin
            data_s1_reg <= i_cpu_d;
            data_s2_reg <= data_s1_reg;
            data_s3_reg <= data_s2_reg;
        end
    end

    logic rd_act;
    logic wr_act;

    assign rd_act = !ctl_filt_reg[2] && !ctl_filt_reg[1];
    assign wr_act = !ctl_filt_reg[2] && !ctl_filt_reg[0] && ctl_filt_reg[1];

    // Access handshake
    pcmq_cpu_state_e cpu_state_reg;
    pcmq_cpu_state_e cpu_state_next;
    logic            accept;

    always_comb
    begin
        cpu_state_next = cpu_state_reg;
        accept         = 1'b0;
        case (cpu_state_reg)
            PCMQ_CPU_IDLE:
            begin
                if (rd_act || wr_act)
                begin
                    accept         = 1'b1;
                    cpu_state_next = PCMQ_CPU_HOLD;
                end
            end
            // New access waits for strobes seen high
            PCMQ_CPU_HOLD:
            begin
                if (!rd_act && !wr_act)
                    cpu_state_next = PCMQ_CPU_IDLE;
            end
            default:
                cpu_state_next = PCMQ_CPU_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cpu_state_reg <= PCMQ_CPU_IDLE;
        else
            cpu_state_reg <= cpu_state_next;
    end

    // Quadrant control registers
    logic [11:0] qctrl_reg [NUM_STREAMS];
    logic [13:0] reg_index;
    logic        hit;

    // Index past NUM_STREAMS reads zero, writes dropped
    assign reg_index = addr_s3_reg - `PCMQ_QCTRL_BASE;
    assign hit       = in_qwin(addr_s3_reg) && (32'(reg_index) < NUM_STREAMS);

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int s = 0; s < NUM_STREAMS; s++)
                qctrl_reg[s] <= `PCMQ_QCTRL_RESET;
        end
        // RULE18 register write
        else if (accept && wr_act && hit)
        begin
            qctrl_reg[reg_index[4:0]] <= data_s3_reg[`PCMQ_QCTRL_BITS-1:0];
        end
    end

    // Drive enable and ready
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_cpu_d_oe      <= 1'b0;
            o_cpu_dta_rdy_n <= 1'b1;
        end
        else
        begin
            o_cpu_d_oe      <= rd_act;
            o_cpu_dta_rdy_n <= (cpu_state_next != PCMQ_CPU_HOLD);
        end
    end

    // Read data holds until the next read
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_cpu_d <= 16'h0000;
        else if (accept && rd_act)
        begin
            // RULE18 register read
            if (hit)
                o_cpu_d <= {4'h0, qctrl_reg[reg_index[4:0]]};
            else
                o_cpu_d <= 16'h0000;
        end
    end

    // Input channel path toward data memory
    pcmq_qctrl_t in_qc;
    logic [11:0] in_reg_sel;

    always_comb
    begin
        // Streams past NUM_STREAMS pass untouched
        in_reg_sel = `PCMQ_QCTRL_RESET;
        if (32'(i_in_stream) < NUM_STREAMS)
            in_reg_sel = qctrl_reg[i_in_stream];
        in_qc = qfield(in_reg_sel, quad_of(i_in_rate, i_in_chan));
    end

    // RULE19 forced bit before memory write
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_dm_valid  <= 1'b0;
            o_dm_stream <= 5'h00;
            o_dm_chan   <= 8'h00;
            o_dm_byte   <= 8'h00;
        end
        else
        begin
            o_dm_valid <= i_in_valid;
            if (i_in_valid)
            begin
                o_dm_stream <= i_in_stream;
                o_dm_chan   <= i_in_chan;
                o_dm_byte   <= bit_replace(in_qc, i_in_byte);
            end
        end
    end

    // RULE1 output channel translation
    pcmq_law_xlate u_xlate
    (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_valid   (i_out_valid),
        .i_cmh     (i_out_cmh),
        .i_byte    (i_out_byte),
        .o_valid   (o_sto_valid),
        .o_byte    (o_sto_byte)
    );

endmodule : pcmq_top
`default_nettype wire

// ### pcmq_top_chk_sva.sv
// Purpose: Port checks for pcmq_top.
// Assumes: Bound to every pcmq_top instance.
// Notes: Voice across A and mu families is checked on the sign bit only.
`timescale 1ns/1ps
`default_nettype none
module pcmq_top_chk
    import pcmq_pkg::*;
#(
    parameter int NUM_STREAMS = 32
)
(
    // Clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    // Port
    input wire logic        i_cpu_cs_n,
    input wire logic [13:0] i_cpu_addr,
    input wire logic [15:0] o_cpu_d,
    input wire logic        o_cpu_d_oe,
    input wire logic        o_cpu_dta_rdy_n,
    // Input path
    input wire logic        i_in_valid,
    input wire logic [4:0]  i_in_stream,
    input wire logic [7:0]  i_in_chan,
    input wire logic [7:0]  i_in_byte,
    input wire logic        o_dm_valid,
    input wire logic [4:0]  o_dm_stream,
    input wire logic [7:0]  o_dm_chan,
    input wire logic [7:0]  o_dm_byte,
    // Output path
    input wire logic        i_out_valid,
    input wire logic [4:0]  i_out_cmh,
    input wire logic [7:0]  i_out_byte,
    input wire logic        o_sto_valid,
    input wire logic [7:0]  o_sto_byte
);
    logic [7:0] exp_byte_reg;
    logic       exp_full_reg;

    function automatic logic [7:0] law_mask(input logic v, input logic [1:0] c);
        if (v)
            law_mask = {4{c}};
        else
            law_mask = c[1] ? 8'h00 : (c[0] ? 8'h7F : 8'h55);
    endfunction : law_mask

    // Expected byte, exact unless voice crosses families
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            exp_byte_reg <= 8'h00;
            exp_full_reg <= 1'b0;
        end
        else if (i_out_valid)
        begin
            exp_byte_reg <= i_out_byte ^ law_mask(i_out_cmh[4], i_out_cmh[3:2]) ^ law_mask(i_out_cmh[4], i_out_cmh[1:0]);
            exp_full_reg <= i_out_cmh[4] | (i_out_cmh[2] == i_out_cmh[0]);
        end
    end

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    dm_pulse_a: assert property (o_dm_valid == $past(i_in_valid))
        else $error("data memory strobe not one cycle after input strobe");
    dm_tag_a: assert property (i_in_valid |=> o_dm_stream == $past(i_in_stream) && o_dm_chan == $past(i_in_chan))
        else $error("stream or channel tag lost");
    dm_mid_a: assert property (i_in_valid |=> o_dm_byte[6:1] == $past(i_in_byte[6:1]))
        else $error("middle bits of input byte changed");
    sto_pulse_a: assert property (o_sto_valid == $past(i_out_valid))
        else $error("output strobe not one cycle after request");
    sto_exact_a: assert property (o_sto_valid && exp_full_reg |-> o_sto_byte == exp_byte_reg)
        else $error("translated byte wrong");
    sto_sign_a: assert property (o_sto_valid |-> o_sto_byte[7] == exp_byte_reg[7])
        else $error("sign bit lost in translation");
    rd_oe_a: assert property (o_cpu_d_oe |-> !o_cpu_dta_rdy_n && o_cpu_d[15:12] == 4'h0)
        else $error("read drive without ready or upper bits set");
    rdy_sync_a: assert property ($fell(o_cpu_dta_rdy_n) |-> !$past(i_cpu_cs_n, 3))
        else $error("ready before strobe passed the sync");
    rdy_bound_a: assert property ($fell(i_cpu_cs_n) |-> ##[3:7] !o_cpu_dta_rdy_n)
        else $error("access not answered in time");
    unmapped_read_a: assert property ($fell(o_cpu_dta_rdy_n) && o_cpu_d_oe
        && (i_cpu_addr < 14'h0120 || i_cpu_addr >= 14'h0120 + NUM_STREAMS) |-> o_cpu_d == 16'h0000)
        else $error("unmapped read not zero");
endmodule : pcmq_top_chk

bind pcmq_top pcmq_top_chk #(.NUM_STREAMS(NUM_STREAMS)) i_pcmq_top_chk (.*);
`default_nettype wire

// ### pcmq_stream_src.sv
// Purpose: Input stream source in front of pcmq_top.
// Assumes: Requests change at the falling edge.
// Notes: Idle byte lines show a moving pattern.
`timescale 1ns/1ps
`default_nettype none
module pcmq_stream_src
(
    // Clock
    input  wire logic       i_clk_sys,
    // Request
    input  wire logic       i_send,
    input  wire logic [4:0] i_stream,
    input  wire logic [7:0] i_chan,
    input  wire logic [1:0] i_rate,
    input  wire logic [7:0] i_byte,
    // Channel toward switch
    output logic            o_in_valid,
    output logic      [4:0] o_in_stream,
    output logic      [7:0] o_in_chan,
    output logic      [1:0] o_in_rate,
    output logic      [7:0] o_in_byte
);
    logic [7:0] idle_reg = 8'hA5;

    always_ff @(posedge i_clk_sys)
    begin
        idle_reg <= ~idle_reg + 8'h01;
    end

    assign o_in_valid = i_send;
    assign o_in_stream = i_stream;
    assign o_in_rate = i_rate;
    assign o_in_chan = i_chan & (8'(32 << i_rate) - 8'h01);
    assign o_in_byte = i_send ? i_byte : idle_reg;
endmodule : pcmq_stream_src
`default_nettype wire

// ### tb.sv
// Purpose: Self-checking bench for pcmq_top.
// Assumes: Inputs change at the falling edge.
// Notes: Cross-law voice uses full-scale codes only.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pcmq_pkg::*;
    logic        i_clk_sys = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_cpu_cs_n = 1'b1, i_cpu_rd_n = 1'b1, i_cpu_wr_n = 1'b1;
    logic [13:0] i_cpu_addr = 14'h0000;
    logic [15:0] i_cpu_d = 16'h0000, o_cpu_d;
    logic        o_cpu_d_oe, o_cpu_dta_rdy_n, s_send = 1'b0;
    logic [4:0]  s_stream = 5'h00, in_stream, o_dm_stream, i_out_cmh = 5'h00;
    logic [7:0]  s_chan = 8'h00, s_byte = 8'h00, in_chan, in_byte, o_dm_chan, o_dm_byte;
    logic [1:0]  s_rate = 2'h0, in_rate;
    logic        in_valid, o_dm_valid, i_out_valid = 1'b0, o_sto_valid;
    logic [7:0]  i_out_byte = 8'h00, o_sto_byte;
    int          err_count = 0;
    int          n_checks = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    pcmq_stream_src i_pcmq_stream_src (.i_clk_sys(i_clk_sys), .i_send(s_send), .i_stream(s_stream),
        .i_chan(s_chan), .i_rate(s_rate), .i_byte(s_byte), .o_in_valid(in_valid),
        .o_in_stream(in_stream), .o_in_chan(in_chan), .o_in_rate(in_rate), .o_in_byte(in_byte));

    pcmq_top i_pcmq_top (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_cpu_cs_n(i_cpu_cs_n),
        .i_cpu_rd_n(i_cpu_rd_n), .i_cpu_wr_n(i_cpu_wr_n), .i_cpu_addr(i_cpu_addr), .i_cpu_d(i_cpu_d),
        .o_cpu_d(o_cpu_d), .o_cpu_d_oe(o_cpu_d_oe), .o_cpu_dta_rdy_n(o_cpu_dta_rdy_n),
        .i_in_valid(in_valid), .i_in_stream(in_stream), .i_in_chan(in_chan), .i_in_rate(in_rate),
        .i_in_byte(in_byte), .o_dm_valid(o_dm_valid), .o_dm_stream(o_dm_stream),
        .o_dm_chan(o_dm_chan), .o_dm_byte(o_dm_byte), .i_out_valid(i_out_valid),
        .i_out_cmh(i_out_cmh), .i_out_byte(i_out_byte), .o_sto_valid(o_sto_valid),
        .o_sto_byte(o_sto_byte));

    task automatic give_verdict();
        if (err_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_rdy(input logic lvl);
        int n;
        n = 0;
        while (o_cpu_dta_rdy_n !== lvl && n < 20)
        begin
            @(negedge i_clk_sys);
            n++;
        end
        check({15'h0000, o_cpu_dta_rdy_n}, {15'h0000, lvl});
    endtask : wait_rdy

    task automatic cpu_xfer(input logic rd, input logic [13:0] a, input logic [15:0] wd, output logic [15:0] q);
        @(negedge i_clk_sys);
        i_cpu_addr = a;
        i_cpu_d = wd;
        i_cpu_cs_n = 1'b0;
        i_cpu_rd_n = !rd;
        i_cpu_wr_n = rd;
        wait_rdy(1'b0);
        q = o_cpu_d;
        check({15'h0000, o_cpu_d_oe}, {15'h0000, rd});
        i_cpu_cs_n = 1'b1;
        i_cpu_rd_n = 1'b1;
        i_cpu_wr_n = 1'b1;
        wait_rdy(1'b1);
        check({15'h0000, o_cpu_d_oe}, 16'h0000);
    endtask : cpu_xfer

    task automatic t_regs();
        logic [15:0] q;
        cpu_xfer(1'b1, 14'h0120, 16'h0000, q);
        check(q, 16'h0000);
        cpu_xfer(1'b0, 14'h013F, 16'hF5A3, q);
        cpu_xfer(1'b1, 14'h013F, 16'h0000, q);
        check(q, 16'h05A3);
        cpu_xfer(1'b0, 14'h0140, 16'h0FFF, q);
        cpu_xfer(1'b1, 14'h0140, 16'h0000, q);
        check(q, 16'h0000);
        cpu_xfer(1'b1, 14'h011F, 16'h0000, q);
        check(q, 16'h0000);
    endtask : t_regs

    task automatic send_in(input logic [4:0] s, input logic [7:0] c, input logic [1:0] r);
        @(negedge i_clk_sys);
        s_send = 1'b1;
        s_stream = s;
        s_chan = c;
        s_rate = r;
        s_byte = 8'h7E;
        @(negedge i_clk_sys);
        s_send = 1'b0;
        check({2'h0, o_dm_valid, o_dm_stream, o_dm_chan}, {2'h0, 1'b1, s, c});
    endtask : send_in

    task automatic t_quad();
        logic [15:0] q;
        logic [7:0]  ch;
        logic [7:0]  qexp [4] = '{8'h7E, 8'h7F, 8'h7E, 8'hFE};
        cpu_xfer(1'b0, 14'h0122, 16'h0FAC, q);
        cpu_xfer(1'b0, 14'h0126, 16'h06DB, q);
        for (int r = 0; r < 4; r++)
            for (int c = 0; c < 8; c++)
            begin
                ch = c[0] ? 8'((((c >> 1) + 1) * 8 << r) - 1) : 8'(((c >> 1) * 8) << r);
                send_in(5'd2, ch, r[1:0]);
                check({8'h00, o_dm_byte}, {8'h00, qexp[c >> 1]});
                send_in(5'd6, ch, r[1:0]);
                check({8'h00, o_dm_byte}, 16'h007E);
            end
    endtask : t_quad

    task automatic send_out(input logic [4:0] cmh, input logic [7:0] b, input logic [7:0] exp);
        @(negedge i_clk_sys);
        i_out_valid = 1'b1;
        i_out_cmh = cmh;
        i_out_byte = b;
        @(negedge i_clk_sys);
        i_out_valid = 1'b0;
        i_out_byte = ~b;
        check({8'h00, o_sto_byte}, {8'h00, exp});
        check({15'h0000, o_sto_valid}, 16'h0001);
    endtask : send_out

    task automatic t_law();
        logic [7:0] dm [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
        logic [7:0] vm [4] = '{8'h55, 8'h7F, 8'h00, 8'h00};
        for (int i = 0; i < 16; i++)
        begin
            send_out({1'b1, i[3:0]}, 8'h3C, 8'h3C ^ dm[i[3:2]] ^ dm[i[1:0]]);
            if (i[2] == i[0])
                send_out({1'b0, i[3:0]}, 8'hC3, 8'hC3 ^ vm[i[3:2]] ^ vm[i[1:0]]);
        end
        send_out(5'b00100, 8'h80, 8'hAA);
        send_out(5'b00100, 8'h00, 8'h2A);
        send_out(5'b01110, 8'hFF, 8'hFF);
    endtask : t_law

    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        t_regs();
        t_quad();
        t_law();
        give_verdict();
    end

    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule : tb
`default_nettype wire
